// *** rtl/sdpram_port.sv ***
// one port of the dual-port ram: input registers, burst counter, output path
// assumes the shared array lives in the parent, read combinationally
`timescale 1ns/100ps
`include "sdpram_regs.svh"
module sdpram_port #(
  parameter int ADDR_W = `SDPRAM_ADDR_W,
  parameter int DATA_W = `SDPRAM_DATA_W,
  parameter int LANE_W = `SDPRAM_LANE_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire sdpram_pkg::sdpram_ctrl_t ctrl,
  input wire logic registered_output_sel,
  input wire logic output_enable_n,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] array_rd_data,
  output logic [ADDR_W-1:0] array_addr,
  output logic array_we,
  output logic [1:0] array_lane_we,
  output logic [DATA_W-1:0] array_wr_data,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  output logic port_active,
  output logic [ADDR_W-1:0] burst_addr
);
  import sdpram_pkg::*;
  localparam int HI_W = DATA_W - LANE_W;
  sdpram_cnt_op_t cnt_op;
  logic [ADDR_W-1:0] count_reg;
  logic [ADDR_W-1:0] count_next;
  logic selected;
  logic sel_reg;
  logic sel_d_reg;
  logic rd_reg;
  logic [1:0] lanes_reg;
  logic [1:0] lanes_d_reg;
  logic rd_d_reg;
  logic [DATA_W-1:0] pipe_reg;
  logic [DATA_W-1:0] flow_data;
  logic drive_rd;
  logic [1:0] drive_lanes;

  assign selected = !ctrl.select_low_n && ctrl.select_high; // [RULE3]

  // counter priority: clear, then load, then advance, else hold; enables ignored
  always_comb begin
    if (!ctrl.count_clear_n) begin
      cnt_op = SDPRAM_CNT_CLEAR; // [RULE6] [RULE26]
    end else if (!ctrl.addr_strobe_n) begin
      cnt_op = SDPRAM_CNT_LOAD; // [RULE2] [RULE5]
    end else if (!ctrl.count_advance_n) begin
      cnt_op = SDPRAM_CNT_INC; // [RULE4]
    end else begin
      cnt_op = SDPRAM_CNT_HOLD; // [RULE29]
    end
  end

  // the access address is the counter value formed on this edge
  always_comb begin
    case (cnt_op)
      SDPRAM_CNT_CLEAR: count_next = '0; // [RULE27]
      SDPRAM_CNT_LOAD: count_next = addr;
      SDPRAM_CNT_INC: count_next = count_reg + 1'b1; // [RULE7] natural wrap
      default: count_next = count_reg;
    endcase
  end

  // counter belongs only to this port clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_reg <= `SDPRAM_ADDR_ZERO;
    end else begin
      count_reg <= count_next; // [RULE28] [RULE23]
    end
  end

  // write in the same edge as the address is taken; array strobes itself
  assign array_addr = count_next; // [RULE8]
  assign array_we = selected && !ctrl.read_write; // [RULE15] [RULE20]
  assign array_lane_we = {!ctrl.high_lane_sel_n, !ctrl.low_lane_sel_n}; // [RULE11] [RULE12]
  assign array_wr_data = data_in; // [RULE24] sampled by the array on the edge
  assign burst_addr = count_reg;

  // registered access state: read flag, lanes, select
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_reg <= 1'b0;
      rd_reg <= 1'b0;
      lanes_reg <= 2'b00;
    end else begin
      sel_reg <= selected; // [RULE21]
      rd_reg <= selected && ctrl.read_write;
      lanes_reg <= {!ctrl.high_lane_sel_n, !ctrl.low_lane_sel_n};
    end
  end

  // flow-through data follows the registered address combinationally
  assign flow_data = array_rd_data;

  // pipeline stage: one more cycle of latency, and a reselect costs a cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pipe_reg <= `SDPRAM_DATA_ZERO;
      rd_d_reg <= 1'b0;
      lanes_d_reg <= 2'b00;
      sel_d_reg <= 1'b0;
    end else begin
      pipe_reg <= flow_data; // [RULE17] [RULE25]
      rd_d_reg <= rd_reg;
      lanes_d_reg <= lanes_reg;
      sel_d_reg <= sel_reg; // [RULE22]
    end
  end

  // pick output path by strap
  always_comb begin
    if (registered_output_sel) begin
      data_out = pipe_reg; // [RULE16]
      drive_rd = rd_d_reg && sel_d_reg;
      drive_lanes = lanes_d_reg;
    end else begin
      data_out = flow_data;
      drive_rd = rd_reg;
      drive_lanes = lanes_reg;
    end
  end

  // output enable acts without the clock on the lane drivers
  assign data_oe = {{HI_W{drive_rd && drive_lanes[1] && !output_enable_n}},
                    {LANE_W{drive_rd && drive_lanes[0] && !output_enable_n}}}; // [RULE13]
  assign port_active = sel_reg;
endmodule

// *** shared/sdpram_regs.svh ***
// constants for the dual-port burst ram ports
// assumes inclusion by bare name from rtl files
`ifndef SDPRAM_REGS_SVH
`define SDPRAM_REGS_SVH
`define SDPRAM_ADDR_W 16
`define SDPRAM_DATA_W 18
`define SDPRAM_LANE_W 9
`define SDPRAM_ADDR_ZERO 16'h0000
`define SDPRAM_DATA_ZERO 18'h00000
`define SDPRAM_CLK_PERIOD_NS 100
`endif

// *** shared/sdpram_pkg.sv ***
// types shared by the dual-port burst ram design
// assumes the constants header is on the include path
`include "sdpram_regs.svh"
package sdpram_pkg;
  // counter action chosen on one port clock edge
  typedef enum logic [1:0] {
    SDPRAM_CNT_HOLD,
    SDPRAM_CNT_LOAD,
    SDPRAM_CNT_INC,
    SDPRAM_CNT_CLEAR
  } sdpram_cnt_op_t;
  // synchronous controls of one port, all active as named
  typedef struct packed {
    logic select_low_n;
    logic select_high;
    logic addr_strobe_n;
    logic count_advance_n;
    logic count_clear_n;
    logic low_lane_sel_n;
    logic high_lane_sel_n;
    logic read_write;
  } sdpram_ctrl_t;
endpackage

// *** rtl/sdpram_top.sv ***
// Function
// [RULE1] master pulls address strobe low for external address
// [RULE2] strobe low loads address into counter
// [RULE3] port selected only with both enables active
// [RULE4] advance low increments counter every clock
// [RULE5] load and clear override advance
// [RULE6] clear zeroes counter, highest priority
// [RULE7] counter wraps past top to zero
// [RULE8] each burst step accesses one successive word
// [RULE9] address width 14, 15 or 16 bits
// [RULE10] upper lane is top bits of word
// [RULE11] low lane select gates its write and read
// [RULE12] high lane select works the same way
// [RULE13] lane driven only with select and enable
// [RULE14] master holds output enable low to read
// [RULE15] read/write low writes, high reads, clocked
// [RULE16] strap high pipelined, low flow-through, per port
// [RULE17] pipelined registers data, flow-through bypasses register
// [RULE18] ports access any location independently, simultaneously
// [RULE19] masters avoid same-location writes from both ports
// [RULE20] write completes inside one clock cycle
// [RULE21] deselect for a cycle idles the port
// [RULE22] pipelined reselect needs one cycle before drive
// [RULE23] clock may be free running or gated
// [RULE24] inputs clocked except asynchronous output enable
// [RULE25] pipelined data one cycle after flow-through
// [RULE26] counter works regardless of chip enables
// [RULE27] counter clear costs no dead cycle
// [RULE28] port state stays in its own clock
// [RULE29] strobe and advance high hold counter
// dual-port synchronous ram: shared array and two port instances
// assumes one common clock drives both ports; masters are same-clock logic
`timescale 1ns/100ps
`include "sdpram_regs.svh"
module sdpram_top #(
  parameter int ADDR_W = `SDPRAM_ADDR_W,
  parameter int DATA_W = `SDPRAM_DATA_W,
  parameter int LANE_W = `SDPRAM_LANE_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire sdpram_pkg::sdpram_ctrl_t a_ctrl,
  input wire logic a_registered_output_sel,
  input wire logic a_output_enable_n,
  input wire logic [DATA_W-1:0] a_data_in,
  output logic [DATA_W-1:0] a_data_out,
  output logic [DATA_W-1:0] a_data_oe,
  output logic a_port_active,
  output logic [ADDR_W-1:0] a_burst_addr,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire sdpram_pkg::sdpram_ctrl_t b_ctrl,
  input wire logic b_registered_output_sel,
  input wire logic b_output_enable_n,
  input wire logic [DATA_W-1:0] b_data_in,
  output logic [DATA_W-1:0] b_data_out,
  output logic [DATA_W-1:0] b_data_oe,
  output logic b_port_active,
  output logic [ADDR_W-1:0] b_burst_addr
);
  import sdpram_pkg::*;
  localparam int DEPTH = 1 << ADDR_W; // [RULE9] depth set by address width
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] a_array_addr;
  logic [ADDR_W-1:0] b_array_addr;
  logic a_we;
  logic b_we;
  logic [1:0] a_lane_we;
  logic [1:0] b_lane_we;
  logic [DATA_W-1:0] a_wdata;
  logic [DATA_W-1:0] b_wdata;
  logic [ADDR_W-1:0] a_rd_addr_reg;
  logic [ADDR_W-1:0] b_rd_addr_reg;

  sdpram_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANE_W(LANE_W)) u_port_a (
    .clock(clock),
    .rstn(rstn),
    .addr(a_addr),
    .ctrl(a_ctrl),
    .registered_output_sel(a_registered_output_sel),
    .output_enable_n(a_output_enable_n),
    .data_in(a_data_in),
    .array_rd_data(mem[a_rd_addr_reg]),
    .array_addr(a_array_addr),
    .array_we(a_we),
    .array_lane_we(a_lane_we),
    .array_wr_data(a_wdata),
    .data_out(a_data_out),
    .data_oe(a_data_oe),
    .port_active(a_port_active),
    .burst_addr(a_burst_addr)
  );

  sdpram_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANE_W(LANE_W)) u_port_b (
    .clock(clock),
    .rstn(rstn),
    .addr(b_addr),
    .ctrl(b_ctrl),
    .registered_output_sel(b_registered_output_sel),
    .output_enable_n(b_output_enable_n),
    .data_in(b_data_in),
    .array_rd_data(mem[b_rd_addr_reg]),
    .array_addr(b_array_addr),
    .array_we(b_we),
    .array_lane_we(b_lane_we),
    .array_wr_data(b_wdata),
    .data_out(b_data_out),
    .data_oe(b_data_oe),
    .port_active(b_port_active),
    .burst_addr(b_burst_addr)
  );

  // read address registers, one per port
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      a_rd_addr_reg <= `SDPRAM_ADDR_ZERO;
      b_rd_addr_reg <= `SDPRAM_ADDR_ZERO;
    end else begin
      a_rd_addr_reg <= a_array_addr; // [RULE18]
      b_rd_addr_reg <= b_array_addr;
    end
  end

  // lane-wise writes; port b written last so a collision leaves b's lanes
  // collisions are the masters' problem, contents then are not guaranteed
  always_ff @(posedge clock) begin
    if (a_we && a_lane_we[0]) begin
      mem[a_array_addr][LANE_W-1:0] <= a_wdata[LANE_W-1:0]; // [RULE11]
    end
    if (a_we && a_lane_we[1]) begin
      mem[a_array_addr][DATA_W-1:LANE_W] <= a_wdata[DATA_W-1:LANE_W]; // [RULE10]
    end
    if (b_we && b_lane_we[0]) begin
      mem[b_array_addr][LANE_W-1:0] <= b_wdata[LANE_W-1:0]; // [RULE12]
    end
    if (b_we && b_lane_we[1]) begin
      mem[b_array_addr][DATA_W-1:LANE_W] <= b_wdata[DATA_W-1:LANE_W]; // [RULE19]
    end
  end
endmodule

// *** verif/sdpram_master.sv ***
// bus master model for one ram port: controls, address, write data
// assumes the bench calls its tasks from one process per port
`timescale 1ns/100ps
module sdpram_master (
  input wire logic clock,
  output logic [15:0] addr,
  output sdpram_pkg::sdpram_ctrl_t ctrl,
  output logic oe_n,
  output logic [17:0] data_in
);
  import sdpram_pkg::*;
  // start deselected so nothing is taken before the first real request
  initial begin
    ctrl = sdpram_ctrl_t'(8'hBF);
    addr = 16'h0000;
    oe_n = 1'b1;
    data_in = 18'h00000;
  end
  // launched just after an edge, held across the next sampling edge
  task automatic cyc(input logic [7:0] c, input logic [15:0] a, input logic [17:0] d);
    @(posedge clock);
    #10;
    ctrl = sdpram_ctrl_t'(c);
    addr = a;
    data_in = c[0] ? ~data_in : d; // reads carry the inverse of the previous data_in, not d
  endtask
  // output enable is asynchronous, so it may move at any time
  task automatic en(input logic v);
    oe_n = v;
  endtask
endmodule

// *** verif/sdpram_top_asserts.sv ***
// port-level checks of counter control and data drive enables
// assumes binding into the ram top; one clock for both ports
`timescale 1ns/100ps
module sdpram_top_asserts #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 18
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire sdpram_pkg::sdpram_ctrl_t a_ctrl,
  input wire logic a_registered_output_sel,
  input wire logic a_output_enable_n,
  input wire logic [DATA_W-1:0] a_data_oe,
  input wire logic [ADDR_W-1:0] a_burst_addr,
  input wire sdpram_pkg::sdpram_ctrl_t b_ctrl,
  input wire logic b_registered_output_sel,
  input wire logic [DATA_W-1:0] b_data_oe
);
  import sdpram_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_strobe_load: assert property (!a_ctrl.addr_strobe_n && a_ctrl.count_clear_n
    |=> a_burst_addr == $past(a_addr)) else $error("strobe load missed");
  chk_clear_zero: assert property (!a_ctrl.count_clear_n
    |=> a_burst_addr == '0) else $error("clear missed");
  chk_count_step: assert property (
    a_ctrl.count_clear_n && a_ctrl.addr_strobe_n && !a_ctrl.count_advance_n
    |=> a_burst_addr == $past(a_burst_addr) + 1'b1) else $error("advance wrong");
  chk_oe_gate: assert property (a_output_enable_n |-> a_data_oe == '0)
    else $error("drive without enable");
  chk_low_gate: assert property (!a_registered_output_sel
    && $past(a_ctrl.low_lane_sel_n) |-> a_data_oe[8:0] == '0) else $error("low lane drive");
  chk_high_gate: assert property (!a_registered_output_sel
    && $past(a_ctrl.high_lane_sel_n) |-> a_data_oe[17:9] == '0) else $error("high lane drive");
  chk_desel_quiet: assert property (
    !$past(!a_ctrl.select_low_n && a_ctrl.select_high) |-> a_data_oe == '0)
    else $error("drive while deselected");
  chk_reselect_wait: assert property (b_registered_output_sel
    && !$past(!b_ctrl.select_low_n && b_ctrl.select_high, 2) |-> b_data_oe == '0)
    else $error("early pipelined drive");
endmodule
bind sdpram_top sdpram_top_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.clock, .rstn,
  .a_addr, .a_ctrl, .a_registered_output_sel, .a_output_enable_n, .a_data_oe, .a_burst_addr,
  .b_ctrl, .b_registered_output_sel, .b_data_oe);

// *** verif/sync_dual_port_ram_burst_port_test.sv ***
// self-checking bench: two master models drive both ports of the ram
// assumes one shared clock; port a flow-through, port b pipelined
`timescale 1ns/100ps
module sync_dual_port_ram_burst_port_test;
  import sdpram_pkg::*;
  logic clock, rstn, a_output_enable_n, b_output_enable_n, a_port_active, b_port_active;
  logic [15:0] a_addr, b_addr, a_burst_addr, b_burst_addr;
  logic [17:0] a_data_in, b_data_in, a_data_out, b_data_out, a_data_oe, b_data_oe;
  sdpram_ctrl_t a_ctrl, b_ctrl;
  logic a_registered_output_sel = 1'b0;
  logic b_registered_output_sel = 1'b1;
  int n_fail = 0;
  int total_checks = 0;
  sdpram_top dut_u (.clock, .rstn, .a_addr, .a_ctrl, .a_registered_output_sel,
    .a_output_enable_n, .a_data_in, .a_data_out, .a_data_oe, .a_port_active, .a_burst_addr,
    .b_addr, .b_ctrl, .b_registered_output_sel, .b_output_enable_n, .b_data_in,
    .b_data_out, .b_data_oe, .b_port_active, .b_burst_addr);
  sdpram_master ma (.clock, .addr(a_addr), .ctrl(a_ctrl), .oe_n(a_output_enable_n),
    .data_in(a_data_in));
  sdpram_master mb (.clock, .addr(b_addr), .ctrl(b_ctrl), .oe_n(b_output_enable_n),
    .data_in(b_data_in));
  // free-running clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog: the sequence needs well under this many cycles
  initial begin
    repeat (400) @(posedge clock);
    n_fail++;
    complete_run();
  end
  // each cyc returns just after the edge that took the previous request
  initial begin
    rstn = 1'b0;
    repeat (4) @(posedge clock);
    #10 rstn = 1'b1;
    ma.en(1'b0);
    mb.en(1'b0);
    ma.cyc(8'h58, 16'h1234, 18'h2A5A5);
    ma.cyc(8'h68, 16'h0000, 18'h15A5A);
    chk(a_burst_addr, 18'h01234);
    ma.cyc(8'h79, 16'h0000, 18'h00000);
    chk(a_burst_addr, 18'h01235);
    ma.cyc(8'h59, 16'h1234, 18'h00000);
    chk(a_data_out, 18'h15A5A);
    chk(a_data_oe, 18'h3FFFF);
    ma.cyc(8'h79, 16'h0000, 18'h00000);
    chk(a_data_out, 18'h2A5A5);
    chk(a_port_active, 18'h00001);
    mb.cyc(8'h59, 16'h1235, 18'h00000);
    mb.cyc(8'h79, 16'h0000, 18'h00000);
    mb.cyc(8'h79, 16'h0000, 18'h00000);
    chk(b_data_out, 18'h15A5A);
    chk(b_data_oe, 18'h3FFFF);
    chk(b_burst_addr, 18'h01235);
    // pipelined deselect only quiets the drivers one edge later
    mb.cyc(8'hBF, 16'h0000, 18'h00000);
    mb.cyc(8'h79, 16'h0000, 18'h00000);
    chk(b_data_oe, 18'h3FFFF);
    chk(b_port_active, 18'h00000);
    mb.cyc(8'h79, 16'h0000, 18'h00000);
    chk(b_data_oe, 18'h00000);
    chk(b_port_active, 18'h00001);
    mb.cyc(8'h79, 16'h0000, 18'h00000);
    chk(b_data_oe, 18'h3FFFF);
    ma.cyc(8'h59, 16'hFFFF, 18'h00000);
    ma.cyc(8'h69, 16'h0000, 18'h00000);
    ma.cyc(8'h79, 16'h0000, 18'h00000);
    chk(a_burst_addr, 18'h00000);
    ma.cyc(8'h41, 16'h0F0F, 18'h00000);
    ma.cyc(8'h70, 16'h0000, 18'h0ABCD);
    chk(a_burst_addr, 18'h00000);
    ma.cyc(8'h49, 16'h0ABC, 18'h00000);
    ma.cyc(8'h59, 16'h0000, 18'h00000);
    chk(a_burst_addr, 18'h00ABC);
    ma.cyc(8'h79, 16'h0000, 18'h00000);
    chk(a_data_out, 18'h0ABCD);
    ma.cyc(8'h5A, 16'h1234, 18'h3FFFF);
    ma.cyc(8'h5D, 16'h1234, 18'h00000);
    ma.cyc(8'h59, 16'h1234, 18'h00000);
    chk(a_data_oe, 18'h3FE00);
    chk(a_data_out & 18'h3FE00, 18'h2A400);
    ma.cyc(8'h79, 16'h0000, 18'h00000);
    chk(a_data_out, 18'h2A5FF);
    ma.en(1'b1);
    #1 chk(a_data_oe, 18'h00000);
    // give the enable back at the usual launch point after an edge
    @(posedge clock);
    #10 ma.en(1'b0);
    ma.cyc(8'h9F, 16'h0777, 18'h00000);
    ma.cyc(8'hBF, 16'h0000, 18'h00000);
    chk(a_burst_addr, 18'h00777);
    chk(a_data_oe, 18'h00000);
    chk(a_port_active, 18'h00000);
    complete_run();
  end
endmodule
